// file: verilog/spsm_pkg.sv
package spsm_pkg;

  // Clock and timing
  localparam int unsigned CLK_PERIOD_NS    = 100;
  localparam int unsigned T_RST_HOLD_NS    = 100000;
  localparam int unsigned T_PARK_HOLD_NS   = 50000;
  localparam int unsigned T_DISCHARGE_NS   = 50000;
  localparam int unsigned TMR_W            = 16;
  localparam int unsigned RST_HOLD_CYC     =
    (T_RST_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned PARK_HOLD_CYC    =
    (T_PARK_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned DISCHARGE_CYC    =
    (T_DISCHARGE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Register map
  localparam int unsigned  REG_AW          = 8;
  localparam int unsigned  REG_DW          = 16;
  localparam logic [7:0]   ADDR_REVISION   = 8'h00;
  localparam logic [7:0]   ADDR_STATUS     = 8'h01;
  localparam logic [15:0]  STATUS_RESET    = 16'h0000;
  localparam logic [15:0]  RDATA_UNMAPPED  = 16'h0000;

  // Revision register field positions
  localparam int unsigned REV_MAJOR_LSB    = 4;
  localparam int unsigned REV_MINOR_LSB    = 0;

  // Status register bit positions
  localparam int unsigned ST_REQ_LOW       = 0;
  localparam int unsigned ST_TEMP_ERR      = 1;
  localparam int unsigned ST_TEMP_WARN     = 2;
  localparam int unsigned ST_RAIL_FAULT    = 3;
  localparam int unsigned ST_OVER_BRIGHT   = 4;
  localparam int unsigned ST_STATE_CHG     = 5;
  localparam int unsigned ST_WD1           = 6;
  localparam int unsigned ST_WD2           = 7;
  localparam int unsigned ST_CSUM_LSB      = 8;
  localparam int unsigned ST_CONV_ERR      = 11;
  localparam int unsigned ST_PARITY        = 12;
  localparam int unsigned ST_RAIL_TIMER    = 13;
  localparam int unsigned ST_DIM_LIMIT     = 14;
  localparam int unsigned ST_FAULT_SUM     = 15;

  // Top-level states, one-hot
  typedef enum logic [10:0] {
    SPSM_OFF       = 11'b000_0000_0001,
    SPSM_EN_1P1    = 11'b000_0000_0010,
    SPSM_EN_1P8    = 11'b000_0000_0100,
    SPSM_EN_3P3    = 11'b000_0000_1000,
    SPSM_RST_HOLD  = 11'b000_0001_0000,
    SPSM_STANDBY   = 11'b000_0010_0000,
    SPSM_POWERING  = 11'b000_0100_0000,
    SPSM_DISP_RDY  = 11'b000_1000_0000,
    SPSM_DISP_ON   = 11'b001_0000_0000,
    SPSM_PARKING   = 11'b010_0000_0000,
    SPSM_SHUTDOWN  = 11'b100_0000_0000
  } spsm_state_t;

  // Monitored supply rails
  typedef struct packed {
    logic in_6v;
    logic r3p3;
    logic r1p8;
    logic r1p1;
  } spsm_rails_t;

  // Host software commands and levels
  typedef struct packed {
    logic power_cycle;
    logic park;
    logic mirror_start;
    logic mirror_powered;
    logic illum_enable;
    logic wd_enable;
  } spsm_sw_t;

  // Event inputs that feed the status register
  typedef struct packed {
    logic       fault_detail_any;
    logic       dimming_pulse_limit;
    logic       mirror_rail_timer_expired;
    logic       parity_error;
    logic       converter_error;
    logic [2:0] checksum_error;
    logic       second_watchdog_error;
    logic       first_watchdog_error;
    logic       over_bright;
    logic       mirror_rail_fault;
  } spsm_evt_t;

  // Register write request
  typedef struct packed {
    logic              wr;
    logic [REG_AW-1:0] addr;
    logic [REG_DW-1:0] wdata;
  } spsm_reg_req_t;

endpackage : spsm_pkg

// file: verilog/spsm_timer.sv
`timescale 1ns/1ps
module spsm_timer #(
  parameter int unsigned W = 16
) (
  input  wire logic         i_mclk,
  input  wire logic         i_resetn,
  input  wire logic         i_load,
  input  wire logic [W-1:0] i_count,
  output logic              o_done
);

  typedef struct packed {
    logic [W-1:0] cnt;
  } spsm_tmr_st_t;

  spsm_tmr_st_t s_r;
  spsm_tmr_st_t s_nxt;

  // Load on request, otherwise count down to zero and hold
  always_comb begin
    s_nxt = s_r;
    if (i_load) begin
      s_nxt.cnt = i_count;
    end else if (s_r.cnt != '0) begin
      s_nxt.cnt = s_r.cnt - W'(1);
    end
  end

  // State register
  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Expiry is never reported in a load cycle
  assign o_done = (s_r.cnt == '0) && !i_load;

endmodule : spsm_timer

// file: verilog/spsm_top.sv
`timescale 1ns/1ps
module spsm_top
  import spsm_pkg::*;
#(
  parameter logic [3:0]  REV_MAJOR     = 4'h1, // Arbitrary value
  parameter logic [3:0]  REV_MINOR     = 4'h0, // Arbitrary value
  parameter int unsigned RST_HOLD      = spsm_pkg::RST_HOLD_CYC,
  parameter int unsigned PARK_HOLD     = spsm_pkg::PARK_HOLD_CYC,
  parameter int unsigned DISCHARGE     = spsm_pkg::DISCHARGE_CYC
) (
  input  wire logic                   i_mclk,
  input  wire logic                   i_resetn,
  input  wire logic                   i_main_supply_good,
  input  wire logic                   i_power_on_request,
  input  wire logic                   i_temp_warning,
  input  wire logic                   i_temp_error,
  input  wire logic                   i_headlight_mode,
  input  wire spsm_pkg::spsm_rails_t  i_rails_good,
  input  wire spsm_pkg::spsm_sw_t     i_sw,
  input  wire spsm_pkg::spsm_evt_t    i_evt,
  input  wire spsm_pkg::spsm_reg_req_t i_reg,
  output logic [spsm_pkg::REG_AW-1:0] o_unused_addr_echo,
  output logic [spsm_pkg::REG_DW-1:0] o_reg_rdata,
  output logic                        o_rail_en_1p1,
  output logic                        o_rail_en_1p8,
  output logic                        o_rail_en_3p3,
  output logic                        o_mirror_reg_en,
  output logic                        o_controller_reset_out_n,
  output logic                        o_park_request_out_n,
  output logic                        o_activity_en,
  output spsm_pkg::spsm_state_t       o_state
);

  import spsm_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // State record

  typedef struct packed {
    spsm_state_t       state;
    logic              park_phase;
    logic              tmr_load;
    logic [TMR_W-1:0]  tmr_count;
    logic              rail_1p1;
    logic              rail_1p8;
    logic              rail_3p3;
    logic              mirror_en;
    logic              ctrl_rst_n;
    logic              park_n;
    logic              active;
    logic [REG_DW-1:0] status;
    logic [REG_DW-1:0] rdata;
    logic [REG_AW-1:0] addr_echo;
  } spsm_top_st_t;

  spsm_top_st_t s_r;
  spsm_top_st_t s_nxt;
  logic         tmr_done;

  ////////////////////////////////////////////////////////////////////////////
  // Helper functions

  // All four monitored rails in range
  function automatic logic rails_ok(input spsm_rails_t r);
    rails_ok = r.r1p1 & r.r1p8 & r.r3p3 & r.in_6v;
  endfunction : rails_ok

  // Cycle count truncated to the timer width
  function automatic logic [TMR_W-1:0] to_cnt(input int unsigned c);
    to_cnt = TMR_W'(c);
  endfunction : to_cnt

  ////////////////////////////////////////////////////////////////////////////
  // Derived conditions

  logic power_good;
  logic wd_error;
  logic park_event;
  logic may_leave_off;

  // Power good means main supply and the four rails
  assign power_good = i_main_supply_good & rails_ok(i_rails_good);

  // Watchdog errors count only while software enables them
  assign wd_error = i_sw.wd_enable &
                    (i_evt.first_watchdog_error |
                     i_evt.second_watchdog_error);

  assign park_event = !power_good | !i_power_on_request | i_temp_error |
                      i_sw.park | i_sw.power_cycle;

  assign may_leave_off = i_main_supply_good & i_power_on_request &
                         !i_temp_warning;

  ////////////////////////////////////////////////////////////////////////////
  // Sequencing timer

  spsm_timer #(
    .W        (TMR_W)
  ) u_timer (
    .i_mclk   (i_mclk),
    .i_resetn (i_resetn),
    .i_load   (s_r.tmr_load),
    .i_count  (s_r.tmr_count),
    .o_done   (tmr_done)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic

  always_comb begin
    s_nxt          = s_r;
    s_nxt.tmr_load = 1'b0;

    // Top-level state machine
    case (s_r.state)
      SPSM_OFF: begin
        s_nxt.rail_1p1   = 1'b0;
        s_nxt.rail_1p8   = 1'b0;
        s_nxt.rail_3p3   = 1'b0;
        s_nxt.mirror_en  = 1'b0;
        s_nxt.ctrl_rst_n = 1'b0;
        s_nxt.active     = 1'b1;
        if (may_leave_off) begin
          s_nxt.state    = SPSM_EN_1P1;
          s_nxt.rail_1p1 = 1'b1;
        end
      end
      SPSM_EN_1P1: begin
        if (!i_power_on_request || !i_main_supply_good) begin
          s_nxt.state = SPSM_OFF;
        end else if (i_rails_good.r1p1) begin
          s_nxt.state    = SPSM_EN_1P8;
          s_nxt.rail_1p8 = 1'b1;
        end
      end
      SPSM_EN_1P8: begin
        if (!i_power_on_request || !i_main_supply_good) begin
          s_nxt.state = SPSM_OFF;
        end else if (i_rails_good.r1p8) begin
          s_nxt.state    = SPSM_EN_3P3;
          s_nxt.rail_3p3 = 1'b1;
        end
      end
      SPSM_EN_3P3: begin
        if (!i_power_on_request || !i_main_supply_good) begin
          s_nxt.state = SPSM_OFF;
        end else if (rails_ok(i_rails_good)) begin
          s_nxt.state     = SPSM_RST_HOLD;
          s_nxt.tmr_load  = 1'b1;
          s_nxt.tmr_count = to_cnt(RST_HOLD);
        end
      end
      SPSM_RST_HOLD: begin
        if (!i_power_on_request || !power_good) begin
          s_nxt.state = SPSM_OFF;
        end else if (tmr_done && !s_r.tmr_load) begin
          s_nxt.state      = SPSM_STANDBY;
          s_nxt.ctrl_rst_n = 1'b1;
        end
      end
      SPSM_STANDBY: begin
        s_nxt.ctrl_rst_n = 1'b1;
        if (i_temp_error) begin
          s_nxt.state = SPSM_SHUTDOWN;
        end else if (!i_power_on_request || i_sw.power_cycle ||
                     wd_error || !power_good) begin
          s_nxt.state = SPSM_OFF;
        end else if (i_sw.mirror_start) begin
          s_nxt.state     = SPSM_POWERING;
          s_nxt.mirror_en = 1'b1;
        end
      end
      SPSM_POWERING: begin
        // request low not acted on here
        if (!power_good || i_temp_error) begin
          s_nxt.state      = SPSM_PARKING;
          s_nxt.park_phase = 1'b0;
          s_nxt.tmr_load   = 1'b1;
          s_nxt.tmr_count  = to_cnt(PARK_HOLD);
        end else if (i_sw.mirror_powered) begin
          s_nxt.state = SPSM_DISP_RDY;
        end
      end
      SPSM_DISP_RDY: begin
        if (park_event) begin
          s_nxt.state      = SPSM_PARKING;
          s_nxt.park_phase = 1'b0;
          s_nxt.tmr_load   = 1'b1;
          s_nxt.tmr_count  = to_cnt(PARK_HOLD);
        end else if (i_sw.illum_enable && !i_headlight_mode) begin
          s_nxt.state = SPSM_DISP_ON;
        end
      end
      SPSM_DISP_ON: begin
        if (park_event) begin
          s_nxt.state      = SPSM_PARKING;
          s_nxt.park_phase = 1'b0;
          s_nxt.tmr_load   = 1'b1;
          s_nxt.tmr_count  = to_cnt(PARK_HOLD);
        end else if (!i_sw.illum_enable || i_headlight_mode) begin
          s_nxt.state = SPSM_DISP_RDY;
        end
      end
      SPSM_PARKING: begin
        if (tmr_done && !s_r.tmr_load) begin
          if (!s_r.park_phase) begin
            s_nxt.mirror_en  = 1'b0;
            s_nxt.park_phase = 1'b1;
            s_nxt.tmr_load   = 1'b1;
            s_nxt.tmr_count  = to_cnt(DISCHARGE);
          end else begin
            s_nxt.state      = SPSM_STANDBY;
            s_nxt.park_phase = 1'b0;
          end
        end
      end
      SPSM_SHUTDOWN: begin
        s_nxt.rail_1p1   = 1'b0;
        s_nxt.rail_1p8   = 1'b0;
        s_nxt.rail_3p3   = 1'b0;
        s_nxt.mirror_en  = 1'b0;
        s_nxt.ctrl_rst_n = 1'b0;
        s_nxt.active     = 1'b0;
        if (!i_power_on_request || !i_main_supply_good) begin
          s_nxt.state  = SPSM_OFF;
          s_nxt.active = 1'b1;
        end
      end
      default: begin
        s_nxt.state = SPSM_OFF;
      end
    endcase

    // Supplies drop on the same edge that enters OFF or SHUTDOWN
    if ((s_nxt.state == SPSM_OFF) || (s_nxt.state == SPSM_SHUTDOWN)) begin
      s_nxt.rail_1p1   = 1'b0;
      s_nxt.rail_1p8   = 1'b0;
      s_nxt.rail_3p3   = 1'b0;
      s_nxt.mirror_en  = 1'b0;
      s_nxt.ctrl_rst_n = 1'b0;
      s_nxt.active     = (s_nxt.state == SPSM_OFF);
    end

    // park low in parking or on temperature error, live or latched
    s_nxt.park_n = !((s_nxt.state == SPSM_PARKING) || i_temp_error ||
                     s_r.status[ST_TEMP_ERR]);

    if (i_reg.wr && (i_reg.addr == ADDR_STATUS)) begin
      s_nxt.status = s_nxt.status | i_reg.wdata;
    end

    s_nxt.status[ST_PARITY] = s_nxt.status[ST_PARITY] | i_evt.parity_error;
    s_nxt.status[ST_WD2]    = s_nxt.status[ST_WD2] |
                              i_evt.second_watchdog_error;
    s_nxt.status[ST_WD1]    = s_nxt.status[ST_WD1] |
                              i_evt.first_watchdog_error;
    s_nxt.status[ST_CSUM_LSB +: 3] = s_nxt.status[ST_CSUM_LSB +: 3] |
                                     i_evt.checksum_error;

    s_nxt.status[ST_RAIL_FAULT] = s_nxt.status[ST_RAIL_FAULT] |
                                  i_evt.mirror_rail_fault;
    s_nxt.status[ST_RAIL_TIMER] = s_nxt.status[ST_RAIL_TIMER] |
                                  i_evt.mirror_rail_timer_expired;
    s_nxt.status[ST_FAULT_SUM]  = s_nxt.status[ST_FAULT_SUM] |
                                  i_evt.fault_detail_any;

    s_nxt.status[ST_TEMP_WARN] = s_nxt.status[ST_TEMP_WARN] | i_temp_warning;
    s_nxt.status[ST_TEMP_ERR]  = s_nxt.status[ST_TEMP_ERR] | i_temp_error;

    s_nxt.status[ST_REQ_LOW]   = s_nxt.status[ST_REQ_LOW] |
                                 !i_power_on_request;
    s_nxt.status[ST_STATE_CHG] = s_nxt.status[ST_STATE_CHG] |
                                 (s_nxt.state != s_r.state);

    s_nxt.status[ST_OVER_BRIGHT] = s_nxt.status[ST_OVER_BRIGHT] |
                                   i_evt.over_bright;
    s_nxt.status[ST_CONV_ERR]    = s_nxt.status[ST_CONV_ERR] |
                                   i_evt.converter_error;
    s_nxt.status[ST_DIM_LIMIT]   = s_nxt.status[ST_DIM_LIMIT] |
                                   i_evt.dimming_pulse_limit;

    // Register read path, one cycle latency
    s_nxt.addr_echo = i_reg.addr;
    case (i_reg.addr)
      ADDR_REVISION: begin
        s_nxt.rdata = {8'h00, REV_MAJOR, REV_MINOR};
      end
      ADDR_STATUS: begin
        s_nxt.rdata = s_r.status;
        s_nxt.rdata[ST_REQ_LOW] = s_r.status[ST_REQ_LOW] |
                                  !i_power_on_request;
      end
      default: begin
        s_nxt.rdata = RDATA_UNMAPPED;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      s_r            <= '0;
      s_r.state      <= SPSM_OFF;
      s_r.park_n     <= 1'b1;
      s_r.active     <= 1'b1;
      s_r.status     <= STATUS_RESET;
      s_r.rdata      <= RDATA_UNMAPPED;
    end else begin
      s_r <= s_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all from flip-flops

  assign o_state                  = s_r.state;
  assign o_rail_en_1p1            = s_r.rail_1p1;
  assign o_rail_en_1p8            = s_r.rail_1p8;
  assign o_rail_en_3p3            = s_r.rail_3p3;
  assign o_mirror_reg_en          = s_r.mirror_en;
  assign o_controller_reset_out_n = s_r.ctrl_rst_n;
  assign o_park_request_out_n     = s_r.park_n;
  assign o_activity_en            = s_r.active;
  assign o_reg_rdata              = s_r.rdata;
  assign o_unused_addr_echo       = s_r.addr_echo;

endmodule : spsm_top

// file: verif/spsm_ctrl_model.sv
`timescale 1ns/1ps
module spsm_ctrl_model
  import spsm_pkg::*;
#(
  parameter int unsigned DELAY = 20
) (
  input  wire logic                  i_mclk,
  input  wire logic                  i_ctrl_reset_n,
  input  wire spsm_pkg::spsm_state_t i_state,
  input  wire logic                  i_run,
  input  wire logic                  i_illum,
  input  wire logic                  i_wd_en,
  input  wire logic                  i_park,
  input  wire logic                  i_cycle,
  output spsm_pkg::spsm_sw_t         o_sw
);
  logic started = 1'b0;
  logic park_d  = 1'b0;
  logic cycle_d = 1'b0;
  int   cnt     = 0;

  initial o_sw = '0;

  ////////////////////////////////////////////////////////////////////////
  // Controller acts only once out of reset; park, power cycle and mirror start are one-cycle pulses, illum and watchdog enables are levels
  always @(negedge i_mclk) begin
    park_d  <= i_park;
    cycle_d <= i_cycle;
    cnt     <= (i_state == SPSM_POWERING) ? cnt + 1 : 0;
    o_sw.illum_enable <= i_illum & i_ctrl_reset_n;
    o_sw.wd_enable    <= i_wd_en & i_ctrl_reset_n;
    o_sw.park         <= i_park & ~park_d & i_ctrl_reset_n;
    o_sw.power_cycle  <= i_cycle & ~cycle_d & i_ctrl_reset_n;
    o_sw.mirror_start <= (i_state == SPSM_STANDBY) & i_run & ~started
                         & i_ctrl_reset_n;
    started <= i_run & (started | (i_state == SPSM_STANDBY));
    o_sw.mirror_powered <= (cnt == DELAY);
  end
endmodule : spsm_ctrl_model

// file: verif/spsm_top_assertions.sv
`timescale 1ns/1ps
module spsm_chk
  import spsm_pkg::*;
#(
  parameter logic [3:0] REV_MAJOR = 4'h1,
  parameter logic [3:0] REV_MINOR = 4'h0
) (
  input wire logic                    i_mclk,
  input wire logic                    i_resetn,
  input wire logic                    i_main_supply_good,
  input wire logic                    i_power_on_request,
  input wire logic                    i_temp_warning,
  input wire logic                    i_temp_error,
  input wire logic                    i_headlight_mode,
  input wire spsm_pkg::spsm_rails_t   i_rails_good,
  input wire spsm_pkg::spsm_sw_t      i_sw,
  input wire spsm_pkg::spsm_reg_req_t i_reg,
  input wire logic [15:0]             o_reg_rdata,
  input wire logic                    o_rail_en_1p1,
  input wire logic                    o_rail_en_1p8,
  input wire logic                    o_rail_en_3p3,
  input wire logic                    o_controller_reset_out_n,
  input wire logic                    o_park_request_out_n,
  input wire spsm_pkg::spsm_state_t   o_state
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_resetn);

  ////////////////////////////////////////////////////////////////////////
  // Power-up steps, standby and park transitions, register reads and shutdown checks
  sequence s_leave_off;
    o_state == SPSM_OFF ##1 o_state == SPSM_EN_1P1;
  endsequence

  a_reset_off: assert property (
    $rose(i_resetn) |-> o_state == SPSM_OFF && !o_rail_en_1p1
      && !o_controller_reset_out_n) else $error("reset not in off");
  a_off_exit: assert property (
    o_state == SPSM_OFF && !(i_main_supply_good && i_power_on_request
      && !i_temp_warning) |=> o_state == SPSM_OFF)
    else $error("left off too early");
  a_first_rail: assert property (
    s_leave_off |-> o_rail_en_1p1 && !o_rail_en_1p8 && !o_rail_en_3p3)
    else $error("first rail wrong");
  a_rail_order: assert property (
    $rose(o_rail_en_3p3) |-> o_rail_en_1p8 && o_rail_en_1p1)
    else $error("rail order wrong");
  a_rails_hold: assert property (
    o_state == SPSM_EN_3P3 && !(&i_rails_good)
      |=> o_state != SPSM_RST_HOLD) else $error("rails not all good");
  a_rst_release: assert property (
    $rose(o_controller_reset_out_n) |-> o_state == SPSM_STANDBY)
    else $error("reset released outside standby");
  a_standby_hot: assert property (
    o_state == SPSM_STANDBY && i_temp_error |=> o_state == SPSM_SHUTDOWN)
    else $error("no shutdown on overheat");
  a_standby_off: assert property (
    o_state == SPSM_STANDBY && !i_temp_error
      && (!i_power_on_request || i_sw.power_cycle) |=> o_state == SPSM_OFF)
    else $error("standby did not go off");
  a_park_event: assert property (
    (o_state == SPSM_DISP_RDY || o_state == SPSM_DISP_ON)
      && (!i_power_on_request || i_sw.park || i_sw.power_cycle
      || i_temp_error) |=> o_state == SPSM_PARKING)
    else $error("park event ignored");
  a_no_disp_on: assert property (
    i_headlight_mode && o_state != SPSM_DISP_ON |=> o_state != SPSM_DISP_ON)
    else $error("headlight entered display on");
  a_temp_park: assert property (
    i_temp_error |=> !o_park_request_out_n) else $error("park not driven");
  a_rev_read: assert property (
    i_reg.addr == ADDR_REVISION |=>
      o_reg_rdata == {8'h00, REV_MAJOR, REV_MINOR})
    else $error("revision read wrong");
  a_status_w1s: assert property (
    (i_reg.wr && i_reg.addr == ADDR_STATUS) ##1 i_reg.addr == ADDR_STATUS
      |=> (o_reg_rdata & $past(i_reg.wdata, 2)) == $past(i_reg.wdata, 2))
    else $error("status bit not set");
  a_shutdown_off: assert property (
    o_state == SPSM_SHUTDOWN |-> !o_rail_en_1p1 && !o_rail_en_1p8
      && !o_rail_en_3p3 && !o_controller_reset_out_n)
    else $error("supply on in shutdown");
endmodule : spsm_chk

bind spsm_top spsm_chk #(.REV_MAJOR(REV_MAJOR), .REV_MINOR(REV_MINOR))
  spsm_chk_inst (.i_mclk, .i_resetn, .i_main_supply_good,
  .i_power_on_request, .i_temp_warning, .i_temp_error, .i_headlight_mode,
  .i_rails_good, .i_sw, .i_reg, .o_reg_rdata, .o_rail_en_1p1,
  .o_rail_en_1p8, .o_rail_en_3p3, .o_controller_reset_out_n,
  .o_park_request_out_n, .o_state);

// file: verif/spsm_top_tb_top.sv
`timescale 1ns/1ps
module spsm_top_tb_top;
  import spsm_pkg::*;
  logic mclk = 1'b0, resetn = 1'b0, main_good = 1'b1, req = 1'b0;
  logic warn = 1'b0, terr = 1'b0, headlight = 1'b0, run = 1'b0;
  logic illum = 1'b0, wd_en = 1'b0, park = 1'b0, cycle = 1'b0;
  spsm_rails_t   rails = '0;
  spsm_evt_t     evt = '0;
  spsm_reg_req_t reg_req = '0;
  spsm_sw_t      sw;
  spsm_state_t   state;
  logic [15:0]   rdata;
  logic [7:0]    echo;
  logic          r1, r2, r3, mir, crst_n, park_n, act;
  int            bad_count = 0;
  int            checks_done = 0;

  always #50 mclk = ~mclk;

  spsm_top #(.REV_MAJOR(4'h3), .REV_MINOR(4'h5), .RST_HOLD(4),
    .PARK_HOLD(4), .DISCHARGE(4)) spsm_top_inst (.i_mclk(mclk),
    .i_resetn(resetn), .i_main_supply_good(main_good),
    .i_power_on_request(req), .i_temp_warning(warn), .i_temp_error(terr),
    .i_headlight_mode(headlight), .i_rails_good(rails), .i_sw(sw),
    .i_evt(evt), .i_reg(reg_req), .o_unused_addr_echo(echo),
    .o_reg_rdata(rdata), .o_rail_en_1p1(r1), .o_rail_en_1p8(r2),
    .o_rail_en_3p3(r3), .o_mirror_reg_en(mir),
    .o_controller_reset_out_n(crst_n), .o_park_request_out_n(park_n),
    .o_activity_en(act), .o_state(state));

  spsm_ctrl_model spsm_ctrl_model_inst (.i_mclk(mclk),
    .i_ctrl_reset_n(crst_n), .i_state(state), .i_run(run), .i_illum(illum),
    .i_wd_en(wd_en), .i_park(park), .i_cycle(cycle), .o_sw(sw));

  ////////////////////////////////////////////////////////////////////////
  // Compare, register access and state helpers
  task automatic cmp(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp

  task automatic reg_wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge mclk);
    reg_req = {1'b1, a, d};
    @(negedge mclk);
    reg_req.wr = 1'b0;
  endtask : reg_wr

  // Read data lands one edge after the address; compared under the caller's mask
  task automatic reg_rd(input logic [7:0] a, input logic [15:0] exp,
                        input logic [15:0] mask);
    @(negedge mclk);
    reg_req = {1'b0, a, 16'h0000};
    @(negedge mclk);
    cmp("rdata", exp & mask, rdata & mask);
    cmp("addr echo", 16'(a), 16'(echo));
  endtask : reg_rd

  task automatic wait_st(input spsm_state_t s);
    int n;
    n = 0;
    while (state !== s && n < 200) begin
      @(negedge mclk);
      n++;
    end
    cmp("state", 16'(s), 16'(state));
  endtask : wait_st

  task automatic hold_st(input spsm_state_t s);
    repeat (6) @(negedge mclk);
    cmp("state", 16'(s), 16'(state));
  endtask : hold_st

  task automatic power_up;
    rails = '0;
    req = 1'b1;
    wait_st(SPSM_EN_1P1);
    cmp("rails", 16'h0001, 16'({r3, r2, r1}));
    rails.r1p1 = 1'b1;
    wait_st(SPSM_EN_1P8);
    cmp("rails", 16'h0003, 16'({r3, r2, r1}));
    rails.r1p8 = 1'b1;
    wait_st(SPSM_EN_3P3);
    cmp("rails", 16'h0007, 16'({r3, r2, r1}));
    rails.r3p3 = 1'b1;
    hold_st(SPSM_EN_3P3);
    rails.in_6v = 1'b1;
    wait_st(SPSM_RST_HOLD);
    cmp("ctrl reset", 16'h0000, 16'(crst_n));
    wait_st(SPSM_STANDBY);
    cmp("ctrl reset", 16'h0001, 16'(crst_n));
  endtask : power_up

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : give_verdict

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (16) @(negedge mclk);
    resetn = 1'b1;
    cmp("state", 16'(SPSM_OFF), 16'(state));
    cmp("outs", 16'h0003, 16'({r1, r2, r3, mir, crst_n, park_n, act}));
    reg_rd(ADDR_STATUS, 16'h0001, 16'hffdf);
    evt = 12'haaa;
    @(negedge mclk);
    evt = '0;
    reg_rd(ADDR_STATUS, 16'haa91, 16'hffdf);
    evt = 12'h555;
    @(negedge mclk);
    evt = '0;
    reg_rd(ADDR_STATUS, 16'hffd9, 16'hffdf);
    reg_wr(ADDR_STATUS, 16'h0004);
    reg_rd(ADDR_STATUS, 16'hffdd, 16'hffdf);
    reg_wr(ADDR_REVISION, 16'hffff);
    reg_rd(ADDR_REVISION, 16'h0035, 16'hffff);
    reg_rd(8'h07, 16'h0000, 16'hffff);
    warn = 1'b1;
    req = 1'b1;
    hold_st(SPSM_OFF);
    warn = 1'b0;
    power_up;
    wd_en = 1'b1;
    @(negedge mclk);
    evt.first_watchdog_error = 1'b1;
    @(negedge mclk);
    evt = '0;
    wait_st(SPSM_OFF);
    wd_en = 1'b0;
    power_up;
    run = 1'b1;
    wait_st(SPSM_POWERING);
    req = 1'b0;
    hold_st(SPSM_POWERING);
    wait_st(SPSM_DISP_RDY);
    wait_st(SPSM_PARKING);
    cmp("park", 16'h0000, 16'(park_n));
    run = 1'b0;
    wait_st(SPSM_STANDBY);
    cmp("mirror", 16'h0000, 16'(mir));
    wait_st(SPSM_OFF);
    power_up;
    headlight = 1'b1;
    illum = 1'b1;
    run = 1'b1;
    wait_st(SPSM_DISP_RDY);
    hold_st(SPSM_DISP_RDY);
    headlight = 1'b0;
    wait_st(SPSM_DISP_ON);
    illum = 1'b0;
    wait_st(SPSM_DISP_RDY);
    illum = 1'b1;
    wait_st(SPSM_DISP_ON);
    cycle = 1'b1;
    wait_st(SPSM_PARKING);
    cycle = 1'b0;
    illum = 1'b0;
    wait_st(SPSM_STANDBY);
    run = 1'b0;
    repeat (2) @(negedge mclk);
    run = 1'b1;
    wait_st(SPSM_DISP_RDY);
    park = 1'b1;
    wait_st(SPSM_PARKING);
    park = 1'b0;
    run = 1'b0;
    wait_st(SPSM_STANDBY);
    terr = 1'b1;
    wait_st(SPSM_SHUTDOWN);
    cmp("halted", 16'h0000, 16'({r1, r2, r3, mir, act, park_n}));
    reg_rd(ADDR_STATUS, 16'h0006, 16'h0006);
    reg_rd(ADDR_STATUS, 16'h0020, 16'h0020);
    req = 1'b0;
    wait_st(SPSM_OFF);
    terr = 1'b0;
    give_verdict;
  end

  // Watchdog: tests need a few hundred cycles, allow twenty thousand
  initial begin
    #2000000;
    bad_count++;
    give_verdict;
  end
endmodule : spsm_top_tb_top
